// >>> rtl/epo_top.sv
`default_nettype none
// Summary of operation
// - Low-rate pulses alternate, 120 ms wide.
// - Second output rises half period later.
// - Period under 550 ms: half-period width.
// - Calibration pulses 90 ms, rate tracks power.
// - Calibration period under 190 ms: half width.
// - Select pins choose the base frequency.
// - No pulses below minimum output frequency.
// - No-load check uses summed phase power.
// - Minimum frequency about 0.0029% of base.
// - Negative total power raises the flag.
// - Positive total power lowers the flag.
// - Flag changes only with calibration pulses.
// - Flag holds until power turns positive.
// - Calibration rate is a selectable multiple.
module epo_top #(
    parameter int unsigned LR_WIDTH_CYC = epo_pkg::LR_WIDTH_CYC,
    parameter int unsigned LR_SHORT_CYC = epo_pkg::LR_SHORT_CYC,
    parameter int unsigned CF_WIDTH_CYC = epo_pkg::CF_WIDTH_CYC,
    parameter int unsigned CF_SHORT_CYC = epo_pkg::CF_SHORT_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Phase power samples from the datapath
    input wire logic power_valid_i,
    input wire logic signed [epo_pkg::PH_W-1:0] phase_a_power_i,
    input wire logic signed [epo_pkg::PH_W-1:0] phase_b_power_i,
    input wire logic signed [epo_pkg::PH_W-1:0] phase_c_power_i,
    // Select pins
    input wire logic rate_scale_sel_i,
    input wire logic freq_sel1_i,
    input wire logic freq_sel0_i,
    // Pulse outputs
    output logic low_rate_pulse_a_o,
    output logic low_rate_pulse_b_o,
    output logic calib_pulse_out_o,
    output logic negative_power_flag_o,
    output logic [2:0] base_freq_setting_o,
    output logic irq_o,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int unsigned SW = epo_pkg::SUM_W;

    // Register file
    logic [31:0] ctrl_reg; // Bit 0 enables pulse generation
    logic [31:0] thresh_reg; // Weighted energy per calibration pulse
    logic [2:0] status_reg; // Sticky events
    logic [2:0] mask_reg; // Interrupt enables
    // Bus holding registers
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    // Energy path
    logic signed [SW-1:0] sum_now; // Total of all three phases
    logic signed [SW-1:0] sum_reg; // Last total seen
    logic [SW-1:0] mag_now;
    logic [43:0] incr_now;
    logic [47:0] acc_reg; // Weighted energy since last pulse
    logic [47:0] thr_eff;
    logic [7:0] cf_cnt_reg; // Calibration pulses since last low-rate pulse
    logic [7:0] mult_now;
    logic [9:0] weight_now;
    logic enable;
    logic creep_block;
    logic accumulate;
    logic cf_evt;
    logic lr_evt;
    logic side_reg; // Low if next low-rate pulse goes to output a
    logic neg_reg;
    logic neg_set_evt;
    logic do_write;
    logic [31:0] wmask;
    logic [2:0] st_set;
    logic [2:0] st_clr;
    epo_pkg::epo_base_type base_now;

    assign enable = ctrl_reg[epo_pkg::CTRL_EN_BIT];

    // Base frequency and multiple from the select pins
    always_comb begin
        case ({rate_scale_sel_i, freq_sel1_i, freq_sel0_i})
            3'b000: begin
                base_now = epo_pkg::BF_2P30;
                mult_now = epo_pkg::M_16;
            end
            3'b100: begin
                base_now = epo_pkg::BF_4P61;
                mult_now = epo_pkg::M_8;
            end
            3'b101: begin
                base_now = epo_pkg::BF_4P61;
                mult_now = epo_pkg::M_16;
            end
            3'b001: begin
                base_now = epo_pkg::BF_1P15;
                mult_now = epo_pkg::M_32;
            end
            3'b110: begin
                base_now = epo_pkg::BF_1P15;
                mult_now = epo_pkg::M_16;
            end
            3'b010: begin
                base_now = epo_pkg::BF_5P22;
                mult_now = epo_pkg::M_160;
            end
            3'b011: begin
                base_now = epo_pkg::BF_0P58;
                mult_now = epo_pkg::M_32;
            end
            default: begin
                base_now = epo_pkg::BF_0P58;
                mult_now = epo_pkg::M_16;
            end
        endcase
        case (base_now)
            epo_pkg::BF_2P30: weight_now = epo_pkg::W_2P30;
            epo_pkg::BF_4P61: weight_now = epo_pkg::W_4P61;
            epo_pkg::BF_1P15: weight_now = epo_pkg::W_1P15;
            epo_pkg::BF_5P22: weight_now = epo_pkg::W_5P22;
            default: weight_now = epo_pkg::W_0P58;
        endcase
    end

    // Registered view of the chosen base frequency
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            base_freq_setting_o <= 3'h0;
        end else begin
            base_freq_setting_o <= base_now;
        end
    end

    assign sum_now = SW'(phase_a_power_i) + SW'(phase_b_power_i) + SW'(phase_c_power_i);
    assign mag_now = sum_now[SW-1] ? SW'(-sum_now) : SW'(sum_now);
    assign creep_block = (mag_now < epo_pkg::CREEP_LIMIT);
    assign accumulate = enable && power_valid_i && !creep_block;
    assign incr_now = 44'(mag_now) * 44'(weight_now) * 44'(mult_now);
    // A zero threshold would fire every cycle; one is the floor
    assign thr_eff = (thresh_reg == 32'h0000_0000) ? 48'h0000_0000_0001 : 48'(thresh_reg);
    assign cf_evt = enable && (acc_reg >= thr_eff);
    assign lr_evt = cf_evt && ((cf_cnt_reg + 8'h01) >= mult_now);

    // Energy accumulator, one calibration pulse per threshold crossed
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_reg <= 48'h0000_0000_0000;
        end else if (!enable) begin
            acc_reg <= 48'h0000_0000_0000;
        end else begin
            acc_reg <= acc_reg - (cf_evt ? thr_eff : 48'h0000_0000_0000)
                + (accumulate ? 48'(incr_now) : 48'h0000_0000_0000);
        end
    end

    // Calibration pulse counter
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cf_cnt_reg <= 8'h00;
        end else if (!enable || lr_evt) begin
            cf_cnt_reg <= 8'h00;
        end else if (cf_evt) begin
            cf_cnt_reg <= cf_cnt_reg + 8'h01;
        end
    end

    // Latest total power, used for the sign
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sum_reg <= '0;
        end else if (power_valid_i) begin
            sum_reg <= sum_now;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            neg_reg <= 1'b0;
        end else if (cf_evt) begin
            if (sum_reg < 0) begin
                neg_reg <= 1'b1;
            end else if (sum_reg > 0) begin
                neg_reg <= 1'b0;
            end
        end
    end
    assign negative_power_flag_o = neg_reg;
    assign neg_set_evt = cf_evt && !neg_reg && (sum_reg < 0);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            side_reg <= 1'b0;
        end else if (lr_evt) begin
            side_reg <= !side_reg;
        end
    end

    epo_pulse_gen #(.WIDTH_CYC(LR_WIDTH_CYC), .SHORT_CYC(LR_SHORT_CYC)) u_pulse_a (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .trigger_i(lr_evt && !side_reg),
        .pulse_o(low_rate_pulse_a_o)
    );
    epo_pulse_gen #(.WIDTH_CYC(LR_WIDTH_CYC), .SHORT_CYC(LR_SHORT_CYC)) u_pulse_b (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .trigger_i(lr_evt && side_reg),
        .pulse_o(low_rate_pulse_b_o)
    );
    epo_pulse_gen #(.WIDTH_CYC(CF_WIDTH_CYC), .SHORT_CYC(CF_SHORT_CYC)) u_pulse_cf (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .trigger_i(cf_evt),
        .pulse_o(calib_pulse_out_o)
    );

    // Bus write path: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= epo_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            case (aw_addr_reg & 8'hFC)
                epo_pkg::REG_CTRL, epo_pkg::REG_CF_THRESH, epo_pkg::REG_STATUS,
                epo_pkg::REG_MASK, epo_pkg::REG_STATE: bresp_reg <= epo_pkg::RESP_OKAY;
                default: bresp_reg <= epo_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Writable registers, byte strobes honoured
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_reg <= epo_pkg::CTRL_RST;
            thresh_reg <= epo_pkg::CF_THRESH_RST;
            mask_reg <= epo_pkg::MASK_RST;
        end else if (do_write) begin
            case (aw_addr_reg & 8'hFC)
                epo_pkg::REG_CTRL: ctrl_reg <= ((ctrl_reg & ~wmask) | (wdata_reg & wmask))
                    & 32'h0000_0001;
                epo_pkg::REG_CF_THRESH: thresh_reg <= (thresh_reg & ~wmask)
                    | (wdata_reg & wmask);
                epo_pkg::REG_MASK: mask_reg <= wstrb_reg[0] ? wdata_reg[2:0] : mask_reg;
                default: ;
            endcase
        end
    end

    // Sticky status: set wins over a same-cycle clear
    assign st_set = {neg_set_evt, lr_evt, cf_evt};
    assign st_clr = (do_write && (aw_addr_reg & 8'hFC) == epo_pkg::REG_STATUS && wstrb_reg[0])
        ? wdata_reg[2:0] : 3'h0;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_reg <= 3'h0;
        end else begin
            status_reg <= (status_reg & ~st_clr) | st_set;
        end
    end
    assign irq_o = |(status_reg & mask_reg);

    // Read path, one outstanding read
    assign s_axi_arready = !rvalid_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= epo_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= epo_pkg::RESP_OKAY;
            case (s_axi_araddr & 8'hFC)
                epo_pkg::REG_CTRL: rdata_reg <= ctrl_reg;
                epo_pkg::REG_CF_THRESH: rdata_reg <= thresh_reg;
                epo_pkg::REG_STATUS: rdata_reg <= {29'h0, status_reg};
                epo_pkg::REG_MASK: rdata_reg <= {29'h0, mask_reg};
                epo_pkg::REG_STATE: rdata_reg <= {25'h0,
                    rate_scale_sel_i, freq_sel1_i, freq_sel0_i,
                    base_freq_setting_o, neg_reg};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= epo_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    property p_neg_only_on_cf;
        @(posedge core_clk_i) disable iff (!nrst_i)
        $changed(negative_power_flag_o) |-> $past(cf_evt);
    endproperty
    a_neg_only_on_cf: assert property (p_neg_only_on_cf) else $error("flag moved off pulse");

    property p_neg_set;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (cf_evt && sum_reg < 0) |=> negative_power_flag_o;
    endproperty
    a_neg_set: assert property (p_neg_set) else $error("flag not set");

    property p_neg_clear;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (cf_evt && sum_reg > 0) |=> !negative_power_flag_o;
    endproperty
    a_neg_clear: assert property (p_neg_clear) else $error("flag not cleared");

    property p_neg_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (negative_power_flag_o && !(cf_evt && sum_reg > 0)) |=> negative_power_flag_o;
    endproperty
    a_neg_hold: assert property (p_neg_hold) else $error("flag dropped early");

    property p_creep_stall;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (power_valid_i && creep_block && !cf_evt && enable) |=> $stable(acc_reg);
    endproperty
    a_creep_stall: assert property (p_creep_stall) else $error("creep accumulated");

    property p_alternate;
        @(posedge core_clk_i) disable iff (!nrst_i)
        lr_evt |=> (side_reg != $past(side_reg)) ##0 (low_rate_pulse_a_o || low_rate_pulse_b_o);
    endproperty
    a_alternate: assert property (p_alternate) else $error("outputs not alternating");

    property p_lr_with_cf;
        @(posedge core_clk_i) disable iff (!nrst_i)
        lr_evt |-> (cf_evt && cf_cnt_reg == mult_now - 8'h01) or (cf_evt && cf_cnt_reg >= mult_now);
    endproperty
    a_lr_with_cf: assert property (p_lr_with_cf) else $error("low-rate not divided");

    property p_map_5p22;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ({rate_scale_sel_i, freq_sel1_i, freq_sel0_i} == 3'b010)
            |=> (base_freq_setting_o == 3'b011);
    endproperty
    a_map_5p22: assert property (p_map_5p22) else $error("base map wrong");
endmodule : epo_top
`default_nettype wire

// >>> rtl/epo_pkg.sv
`default_nettype none
package epo_pkg;
    // Core clock
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // Low-rate pulse timing
    localparam int unsigned LR_WIDTH_MS = 120;
    localparam int unsigned LR_SHORT_MS = 550;
    localparam int unsigned LR_WIDTH_CYC = LR_WIDTH_MS * CYC_PER_MS;
    localparam int unsigned LR_SHORT_CYC = LR_SHORT_MS * CYC_PER_MS;
    // Calibration pulse timing
    localparam int unsigned CF_WIDTH_MS = 90;
    localparam int unsigned CF_SHORT_MS = 190;
    localparam int unsigned CF_WIDTH_CYC = CF_WIDTH_MS * CYC_PER_MS;
    localparam int unsigned CF_SHORT_CYC = CF_SHORT_MS * CYC_PER_MS;
    // Power sample widths
    localparam int unsigned PH_W = 24;
    localparam int unsigned SUM_W = PH_W + 2;
    // No-load limit: 29 parts per million of three-phase full scale
    localparam int unsigned CREEP_NUM = 29;
    localparam int unsigned CREEP_DEN = 1_000_000;
    localparam logic [SUM_W-1:0] CREEP_LIMIT =
        SUM_W'((3 * (2 ** (PH_W - 1)) * CREEP_NUM) / CREEP_DEN);
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CF_THRESH = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] CF_THRESH_RST = 32'h0100_0000;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Field positions
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned ST_CF_BIT = 0;
    localparam int unsigned ST_LR_BIT = 1;
    localparam int unsigned ST_NEG_BIT = 2;
    localparam int unsigned STATE_NEG_BIT = 0;
    localparam int unsigned STATE_BASE_LSB = 1;
    localparam int unsigned STATE_SEL_LSB = 4;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Base frequency settings
    typedef enum logic [2:0] {
        BF_2P30 = 3'b000,
        BF_4P61 = 3'b001,
        BF_1P15 = 3'b010,
        BF_5P22 = 3'b011,
        BF_0P58 = 3'b100
    } epo_base_type;
    // Base frequency weights in hundredths of a hertz
    localparam logic [9:0] W_2P30 = 10'h0E6;
    localparam logic [9:0] W_4P61 = 10'h1CD;
    localparam logic [9:0] W_1P15 = 10'h073;
    localparam logic [9:0] W_5P22 = 10'h20A;
    localparam logic [9:0] W_0P58 = 10'h03A;
    // Calibration-to-low-rate multiples
    localparam logic [7:0] M_8 = 8'h08;
    localparam logic [7:0] M_16 = 8'h10;
    localparam logic [7:0] M_32 = 8'h20;
    localparam logic [7:0] M_160 = 8'hA0;
endpackage : epo_pkg
`default_nettype wire

// >>> rtl/epo_pulse_gen.sv
`default_nettype none
// Stretches a one-cycle trigger into a timed high pulse
module epo_pulse_gen #(
    parameter int unsigned WIDTH_CYC = epo_pkg::LR_WIDTH_CYC,
    parameter int unsigned SHORT_CYC = epo_pkg::LR_SHORT_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic trigger_i,
    output logic pulse_o
);
    logic [31:0] since_reg; // Cycles since last trigger, saturating
    logic [31:0] left_reg; // High cycles still to go
    logic [31:0] width_reg; // Width chosen at last trigger
    logic [31:0] width_next;
    logic [31:0] hi_cnt_reg; // Checking aid: cycles seen high
    logic pulse_reg;

    // Period measurement; starts saturated so the first pulse is nominal
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_reg <= 32'hFFFF_FFFF;
        end else if (trigger_i) begin
            since_reg <= 32'h0000_0001;
        end else if (since_reg != 32'hFFFF_FFFF) begin
            since_reg <= since_reg + 32'h0000_0001;
        end
    end

    // Width choice
    always_comb begin
        if (since_reg < SHORT_CYC) begin
            width_next = since_reg >> 1;
        end else begin
            width_next = WIDTH_CYC;
        end
        // Never less than one cycle
        if (width_next == 32'h0000_0000) begin
            width_next = 32'h0000_0001;
        end
    end

    // Pulse timer; a retrigger restarts the pulse
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            left_reg <= 32'h0000_0000;
            width_reg <= 32'h0000_0000;
            pulse_reg <= 1'b0;
        end else if (trigger_i) begin
            left_reg <= width_next - 32'h0000_0001;
            width_reg <= width_next;
            pulse_reg <= 1'b1;
        end else if (left_reg != 32'h0000_0000) begin
            left_reg <= left_reg - 32'h0000_0001;
        end else begin
            pulse_reg <= 1'b0;
        end
    end

    assign pulse_o = pulse_reg;

    // Checking aid: counts the high cycles of the current pulse
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt_reg <= 32'h0000_0000;
        end else if (trigger_i) begin
            hi_cnt_reg <= 32'h0000_0000;
        end else if (pulse_reg) begin
            hi_cnt_reg <= hi_cnt_reg + 32'h0000_0001;
        end
    end

    property p_pulse_start;
        @(posedge core_clk_i) disable iff (!nrst_i)
        trigger_i |=> pulse_o;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

    property p_pulse_width;
        @(posedge core_clk_i) disable iff (!nrst_i)
        $fell(pulse_o) |-> (hi_cnt_reg == width_reg);
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");

    property p_short_half;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (trigger_i && since_reg < SHORT_CYC && since_reg > 32'h0000_0001)
            |=> (width_reg == ($past(since_reg) >> 1));
    endproperty
    a_short_half: assert property (p_short_half) else $error("short period width");
endmodule : epo_pulse_gen
`default_nettype wire

// >>> testbench/epo_pulse_counter.sv
`default_nettype none
// Far-side counter: counts rising edges and times each finished pulse
module epo_pulse_counter (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] pulse_i,
    output var int cnt_o [3],
    output var int width_o [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    int run [3]; // Cycles high so far
    logic [2:0] last; // Previous level, for edges
    // Index 0 and 1 low-rate outputs, 2 calibration
    always_ff @(posedge clk_i or negedge nrst_i) begin
        for (int k = 0; k < 3; k++) begin
            if (!nrst_i) begin
                cnt_o[k] <= 0;
                width_o[k] <= 0;
                run[k] <= 0;
            end else begin
                if (pulse_i[k] && !last[k]) cnt_o[k] <= cnt_o[k] + 1;
                if (pulse_i[k]) run[k] <= run[k] + 1;
                else if (run[k] != 0) begin
                    // Width known only once the pulse has ended
                    width_o[k] <= run[k];
                    run[k] <= 0;
                end
            end
        end
        last <= nrst_i ? pulse_i : 3'h0;
    end
endmodule : epo_pulse_counter
`default_nettype wire

// >>> testbench/tb_epo_top.sv
`default_nettype none
module tb_epo_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, nrst_i, power_valid_i, rate_scale_sel_i, freq_sel1_i, freq_sel0_i;
    logic signed [23:0] phase_a_power_i, phase_b_power_i, phase_c_power_i;
    logic low_rate_pulse_a_o, low_rate_pulse_b_o, calib_pulse_out_o, negative_power_flag_o, irq_o;
    logic [2:0] base_freq_setting_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_count, cmp_count, seed;
    int cnt [3];
    int wid [3];
    // Short widths keep the run brief
    epo_top #(.LR_WIDTH_CYC(120), .LR_SHORT_CYC(550), .CF_WIDTH_CYC(90), .CF_SHORT_CYC(190))
    i_epo_top (.core_clk_i, .nrst_i, .power_valid_i, .phase_a_power_i, .phase_b_power_i,
        .phase_c_power_i, .rate_scale_sel_i, .freq_sel1_i, .freq_sel0_i, .low_rate_pulse_a_o,
        .low_rate_pulse_b_o, .calib_pulse_out_o, .negative_power_flag_o, .base_freq_setting_o,
        .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    epo_pulse_counter i_epo_pulse_counter (.clk_i(core_clk_i), .nrst_i(nrst_i), .cnt_o(cnt),
        .pulse_i({calib_pulse_out_o, low_rate_pulse_b_o, low_rate_pulse_a_o}), .width_o(wid));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic results();
        $display("Checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Ready and answers sampled at the rising edge; bready/rready simply stay up
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk("read", s_axi_rdata, e);
        chk("resp", 32'(s_axi_rresp), 32'(r));
    endtask : rd
    // Random phases summing to s
    task automatic smp(input int s);
        logic [8:0] x;
        x = 9'($random(seed));
        phase_a_power_i <= 24'(x);
        phase_b_power_i <= 24'(s / 2 - int'(x));
        phase_c_power_i <= 24'(s - s / 2);
        power_valid_i <= 1'b1;
        @(posedge core_clk_i);
        power_valid_i <= 1'b0;
    endtask : smp
    function automatic logic [2:0] exp_base(input logic [2:0] s);
        case (s)
            3'h0: return epo_pkg::BF_2P30;
            3'h4, 3'h5: return epo_pkg::BF_4P61;
            3'h1, 3'h6: return epo_pkg::BF_1P15;
            3'h2: return epo_pkg::BF_5P22;
            default: return epo_pkg::BF_0P58;
        endcase
    endfunction : exp_base
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        results();
    end
    initial begin
        {nrst_i, power_valid_i, rate_scale_sel_i, freq_sel1_i, freq_sel0_i} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {phase_a_power_i, phase_b_power_i, phase_c_power_i} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        seed = 46;
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(posedge core_clk_i);
        rd(epo_pkg::REG_CTRL, epo_pkg::CTRL_RST, epo_pkg::RESP_OKAY);
        rd(epo_pkg::REG_CF_THRESH, epo_pkg::CF_THRESH_RST, epo_pkg::RESP_OKAY);
        rd(epo_pkg::REG_MASK, 32'h0, epo_pkg::RESP_OKAY);
        rd(8'h14, 32'h0, epo_pkg::RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            {rate_scale_sel_i, freq_sel1_i, freq_sel0_i} <= 3'(i);
            repeat (3) @(posedge core_clk_i);
            chk("base", 32'(base_freq_setting_o), 32'(exp_base(3'(i))));
        end
        // 4.61 Hz x8: a 1000 sample is one step
        {rate_scale_sel_i, freq_sel1_i, freq_sel0_i} <= 3'h4;
        wr(epo_pkg::REG_CF_THRESH, 32'h0038_4640);
        wr(epo_pkg::REG_MASK, 32'h0000_0004);
        smp(700);
        repeat (200) @(posedge core_clk_i);
        chk("creep", 32'(cnt[2]), 32'h0);
        for (int i = 1; i <= 16; i++) begin
            smp(1000);
            repeat (300) @(posedge core_clk_i);
            chk("cf width", 32'(wid[2]), 32'd90);
            chk("a count", 32'(cnt[0]), 32'((i / 8 + 1) / 2));
            chk("b count", 32'(cnt[1]), 32'(i / 16));
        end
        chk("lr width", 32'(wid[1]), 32'd120);
        smp(1000);
        repeat (100) @(posedge core_clk_i);
        smp(1000);
        repeat (200) @(posedge core_clk_i);
        chk("cf half", 32'(wid[2]), 32'd50);
        smp(-1000);
        repeat (5) @(posedge core_clk_i);
        chk("flag", 32'(negative_power_flag_o), 32'h1);
        chk("irq", 32'(irq_o), 32'h1);
        rd(epo_pkg::REG_STATUS, 32'h0000_0007, epo_pkg::RESP_OKAY);
        wr(epo_pkg::REG_STATUS, 32'h0000_0007);
        chk("irq clr", 32'(irq_o), 32'h0);
        smp(700);
        repeat (300) @(posedge core_clk_i);
        chk("flag hold", 32'(negative_power_flag_o), 32'h1);
        smp(1000);
        repeat (5) @(posedge core_clk_i);
        chk("flag low", 32'(negative_power_flag_o), 32'h0);
        results();
    end
endmodule : tb_epo_top
`default_nettype wire
